// ### design/cao_pkg.sv
/*
  Constants shared by the common alarm and status block.
  Assumes a single 125 MHz clock and same-domain producers for all inputs.
*/
package cao_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NUM_CH = 4;
  localparam int NUM_STR = 2;
  localparam int NUM_COMP = 4;
  localparam int NUM_DOUT = 8;
  localparam int DOUT_SEL_W = 3;
  localparam int VAL_W = 16;
  localparam int CH_ALM = 10;
  localparam int STR_ALM = 5;
  localparam int NUM_ALM = NUM_CH * CH_ALM + NUM_STR * STR_ALM;
  localparam int ALM_ID_W = 6;
  localparam int EN_W = 6;

  // ----------------------------------------
  // channel alarm positions
  // ----------------------------------------
  localparam int A_TIMEOUT = 0;
  localparam int A_HI = 1;
  localparam int A_UPPER_UPPER_LIMIT = 2;
  localparam int A_FAIL = 3;
  localparam int A_LO = 4;
  localparam int A_LOWER_LOWER_LIMIT = 5;
  localparam int A_OVER = 6;
  localparam int A_PIN_OVL = 7;
  localparam int A_POUT_OVL = 8;
  localparam int A_UNDER = 9;
  // limit enable positions
  localparam int EN_HI = 0;
  localparam int EN_UPPER_UPPER_LIMIT = 1;
  localparam int EN_LO = 2;
  localparam int EN_LOWER_LOWER_LIMIT = 3;
  localparam int EN_OVER = 4;
  localparam int EN_UNDER = 5;

  // ----------------------------------------
  // stream alarm positions
  // ----------------------------------------
  localparam int S_CRIT = 0;
  localparam int S_CUTOFF = 1;
  localparam int S_DP = 2;
  localparam int S_COMP = 3;
  localparam int S_CALC = 4;

  // ----------------------------------------
  // timing and thresholds
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;
  localparam logic [9:0] FLASH_HALF_MS = 10'h1f4;
  localparam logic [15:0] PULSE_IN_MAX_HZ = 16'h2ee0;
  localparam logic [31:0] PULSE_OUT_WINDOW_S = 32'h0000000a;
  localparam logic [7:0] PCT_FULL = 8'h64;
  localparam logic [7:0] CRIT_NUM = 8'h03;
  localparam logic [7:0] CRIT_DEN = 8'h02;
  localparam logic [VAL_W-1:0] FLOW_ZERO = 16'h0000;
  // composition in 0.01 % units
  localparam logic [17:0] COMP_SUM_MIN = 18'h0251c;
  localparam logic [17:0] COMP_SUM_MAX = 18'h02904;
  localparam logic [7:0] CALC_MAX_ITER = 8'h0a;

  // ----------------------------------------
  // log record kinds and sender states
  // ----------------------------------------
  typedef enum logic [1:0] {
    LOG_SET = 2'h1,
    LOG_ACK = 2'h2,
    LOG_CLR = 2'h3
  } cao_log_kind_t;

  typedef enum logic [0:0] {
    LOG_IDLE = 1'h0,
    LOG_BUSY = 1'h1
  } cao_log_state_t;
endpackage

// ### design/cao_chan_eval.sv
/*
  Alarm evaluator for one I/O channel: limits, scale, pulse and timeout.
  Assumes a one-cycle millisecond tick from the parent, same clock.
*/
`timescale 1ns/1ns
module cao_chan_eval (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic ms_tick_i,
  input wire logic [cao_pkg::VAL_W-1:0] value_i,
  input wire logic [cao_pkg::VAL_W-1:0] upper_limit_i,
  input wire logic [cao_pkg::VAL_W-1:0] upper_upper_limit_i,
  input wire logic [cao_pkg::VAL_W-1:0] lower_limit_i,
  input wire logic [cao_pkg::VAL_W-1:0] lower_lower_limit_i,
  input wire logic [cao_pkg::VAL_W-1:0] scale_hi_i,
  input wire logic [cao_pkg::VAL_W-1:0] scale_lo_i,
  input wire logic [cao_pkg::EN_W-1:0] limit_en_i,
  input wire logic fresh_i,
  input wire logic [15:0] timeout_ms_i,
  input wire logic read_fail_i,
  input wire logic [15:0] freq_hz_i,
  input wire logic [31:0] pulse_backlog_i,
  input wire logic [15:0] pulse_out_max_hz_i,
  output logic [cao_pkg::CH_ALM-1:0] alarm_o
);
  import cao_pkg::*;

  typedef struct packed {
    logic [15:0] age_ms;
    logic [CH_ALM-1:0] alm;
  } cao_chan_t;

  cao_chan_t s;
  cao_chan_t n;
  logic [31:0] pulse_cap;

  always_comb begin
    n = s;
    pulse_cap = pulse_out_max_hz_i * PULSE_OUT_WINDOW_S;
    if (fresh_i) begin
      n.age_ms = '0;
    end else if (ms_tick_i && s.age_ms != '1) begin
      n.age_ms = s.age_ms + 1'b1;
    end
    // zero timeout disables the check
    n.alm[A_TIMEOUT] = (timeout_ms_i != '0) && (s.age_ms >= timeout_ms_i);
    n.alm[A_HI] = limit_en_i[EN_HI] && (value_i > upper_limit_i);
    n.alm[A_UPPER_UPPER_LIMIT] = limit_en_i[EN_UPPER_UPPER_LIMIT] && (value_i > upper_upper_limit_i);
    n.alm[A_LO] = limit_en_i[EN_LO] && (value_i < lower_limit_i);
    n.alm[A_LOWER_LOWER_LIMIT] = limit_en_i[EN_LOWER_LOWER_LIMIT] && (value_i < lower_lower_limit_i);
    n.alm[A_OVER] = limit_en_i[EN_OVER] && (value_i > scale_hi_i);
    n.alm[A_UNDER] = limit_en_i[EN_UNDER] && (value_i < scale_lo_i);
    n.alm[A_PIN_OVL] = freq_hz_i > PULSE_IN_MAX_HZ;
    n.alm[A_POUT_OVL] = pulse_backlog_i > pulse_cap;
    n.alm[A_FAIL] = read_fail_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign alarm_o = s.alm;
endmodule

// ### design/cao_alarm_top.sv
/*
  Common alarm and status outputs: alarm aggregation, acknowledge,
  lamp flashing, alarm contact routing, run status and alarm logging.
  Assumes all inputs come from logic on ref_clk_i, and a log sink
  that takes records with a valid/ready handshake.
*/
`timescale 1ns/1ns
module cao_alarm_top #(
  parameter int CYC_PER_MS = cao_pkg::CYC_PER_MS_DEF
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [cao_pkg::NUM_CH-1:0][cao_pkg::VAL_W-1:0] ch_value_i,
  input wire logic [cao_pkg::NUM_CH-1:0][cao_pkg::VAL_W-1:0] ch_upper_limit_i,
  input wire logic [cao_pkg::NUM_CH-1:0][cao_pkg::VAL_W-1:0] ch_upper_upper_limit_i,
  input wire logic [cao_pkg::NUM_CH-1:0][cao_pkg::VAL_W-1:0] ch_lower_limit_i,
  input wire logic [cao_pkg::NUM_CH-1:0][cao_pkg::VAL_W-1:0] ch_lower_lower_limit_i,
  input wire logic [cao_pkg::NUM_CH-1:0][cao_pkg::VAL_W-1:0] ch_scale_hi_i,
  input wire logic [cao_pkg::NUM_CH-1:0][cao_pkg::VAL_W-1:0] ch_scale_lo_i,
  input wire logic [cao_pkg::NUM_CH-1:0][cao_pkg::EN_W-1:0] ch_limit_en_i,
  input wire logic [cao_pkg::NUM_CH-1:0] ch_fresh_i,
  input wire logic [cao_pkg::NUM_CH-1:0][15:0] ch_timeout_ms_i,
  input wire logic [cao_pkg::NUM_CH-1:0] ch_read_fail_i,
  input wire logic [cao_pkg::NUM_CH-1:0][15:0] ch_freq_hz_i,
  input wire logic [cao_pkg::NUM_CH-1:0][31:0] ch_pulse_backlog_i,
  input wire logic [15:0] pulse_out_max_hz_i,
  input wire logic [cao_pkg::NUM_STR-1:0][cao_pkg::VAL_W-1:0] st_uncorrected_volume_flow_i,
  input wire logic [cao_pkg::NUM_STR-1:0][cao_pkg::VAL_W-1:0] st_max_flow_i,
  input wire logic [cao_pkg::NUM_STR-1:0][7:0] st_max_load_factor_i,
  input wire logic [cao_pkg::NUM_STR-1:0][cao_pkg::VAL_W-1:0] st_cutoff_flow_i,
  input wire logic [cao_pkg::NUM_STR-1:0][cao_pkg::VAL_W-1:0] st_differential_pressure_i,
  input wire logic [cao_pkg::NUM_STR-1:0][cao_pkg::VAL_W-1:0] st_dp_cutoff_i,
  input wire logic [cao_pkg::NUM_STR-1:0][cao_pkg::NUM_COMP-1:0][15:0] st_comp_i,
  input wire logic [cao_pkg::NUM_STR-1:0][7:0] st_iter_i,
  input wire logic [cao_pkg::NUM_STR-1:0] st_converged_i,
  input wire logic ack_i,
  input wire logic fault_i,
  input wire logic [cao_pkg::DOUT_SEL_W-1:0] alarm_out_sel_i,
  input wire logic alarm_out_nc_i,
  input wire logic [cao_pkg::NUM_DOUT-1:0] dout_user_i,
  input wire logic log_ready_i,
  output logic common_alarm_o,
  output logic alarm_led_o,
  output logic [cao_pkg::NUM_DOUT-1:0] dout_o,
  output logic run_led_o,
  output logic in_op_contact_o,
  output logic in_fault_contact_o,
  output logic log_valid_o,
  output logic [cao_pkg::ALM_ID_W-1:0] log_id_o,
  output logic [1:0] log_kind_o,
  output logic [cao_pkg::NUM_ALM-1:0] alarm_active_o,
  output logic [cao_pkg::NUM_ALM-1:0] alarm_unacked_o
);
  import cao_pkg::*;

  localparam int MS_W = $clog2(CYC_PER_MS);

  typedef struct packed {
    logic [MS_W-1:0] ms_cnt;
    logic [9:0] flash_cnt;
    logic flash_ph;
    logic [NUM_ALM-1:0] active;
    logic [NUM_ALM-1:0] unacked;
    logic [NUM_ALM-1:0] logged_act;
    logic [NUM_ALM-1:0] logged_ack;
    cao_log_state_t lstate;
    logic [ALM_ID_W-1:0] log_id;
    cao_log_kind_t log_kind;
    logic common;
    logic alarm_led;
    logic [NUM_DOUT-1:0] dout;
    logic run_led;
    logic in_op;
    logic in_fault;
  } cao_top_t;

  cao_top_t s;
  cao_top_t n;
  logic ms_tick;
  logic [NUM_CH-1:0][CH_ALM-1:0] ch_alm;
  logic [NUM_STR-1:0][STR_ALM-1:0] st_alm;
  logic [NUM_ALM-1:0] cond;
  logic [NUM_ALM-1:0] pend_set;
  logic [NUM_ALM-1:0] pend_ack;
  logic [NUM_ALM-1:0] pend_clr;
  logic found;
  logic [ALM_ID_W-1:0] found_id;
  cao_log_kind_t found_kind;
  logic any_act;
  logic any_unack;
  logic [17:0] comp_sum;
  logic [39:0] crit_lhs;
  logic [39:0] crit_rhs;

  // one shared millisecond tick keeps the channel timers in step
  assign ms_tick = (s.ms_cnt == MS_W'(CYC_PER_MS - 1));

  // ----------------------------------------
  // channel evaluators
  // ----------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    cao_chan_eval u_eval (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .ms_tick_i(ms_tick),
      .value_i(ch_value_i[c]),
      .upper_limit_i(ch_upper_limit_i[c]),
      .upper_upper_limit_i(ch_upper_upper_limit_i[c]),
      .lower_limit_i(ch_lower_limit_i[c]),
      .lower_lower_limit_i(ch_lower_lower_limit_i[c]),
      .scale_hi_i(ch_scale_hi_i[c]),
      .scale_lo_i(ch_scale_lo_i[c]),
      .limit_en_i(ch_limit_en_i[c]),
      .fresh_i(ch_fresh_i[c]),
      .timeout_ms_i(ch_timeout_ms_i[c]),
      .read_fail_i(ch_read_fail_i[c]),
      .freq_hz_i(ch_freq_hz_i[c]),
      .pulse_backlog_i(ch_pulse_backlog_i[c]),
      .pulse_out_max_hz_i(pulse_out_max_hz_i),
      .alarm_o(ch_alm[c])
    );
  end

  // ----------------------------------------
  // stream checks
  // ----------------------------------------
  always_comb begin
    st_alm = '0;
    comp_sum = '0;
    crit_lhs = '0;
    crit_rhs = '0;
    for (int t = 0; t < NUM_STR; t++) begin
      // percent load, so scale both sides by 100 x 2
      // 40 bits so the three-way product never wraps
      crit_lhs = 40'(st_uncorrected_volume_flow_i[t]) * 40'(PCT_FULL) * 40'(CRIT_DEN);
      crit_rhs = 40'(CRIT_NUM) * 40'(st_max_load_factor_i[t]) * 40'(st_max_flow_i[t]);
      st_alm[t][S_CRIT] = crit_lhs > crit_rhs;
      st_alm[t][S_CUTOFF] = (st_uncorrected_volume_flow_i[t] > FLOW_ZERO)
        && (st_uncorrected_volume_flow_i[t] < st_cutoff_flow_i[t]);
      st_alm[t][S_DP] = st_differential_pressure_i[t] < st_dp_cutoff_i[t];
      comp_sum = '0;
      for (int k = 0; k < NUM_COMP; k++) begin
        comp_sum = comp_sum + 18'(st_comp_i[t][k]);
      end
      st_alm[t][S_COMP] = (comp_sum < COMP_SUM_MIN) || (comp_sum > COMP_SUM_MAX);
      st_alm[t][S_CALC] = !st_converged_i[t] && (st_iter_i[t] >= CALC_MAX_ITER);
    end
  end

  assign cond = {st_alm, ch_alm};

  // ----------------------------------------
  // log pending scan
  // ----------------------------------------
  always_comb begin
    pend_set = s.active & ~s.logged_act;
    pend_ack = s.active & ~s.unacked & s.logged_act & ~s.logged_ack;
    pend_clr = ~s.active & s.logged_act;
    found = 1'b0;
    found_id = '0;
    found_kind = LOG_SET;
    // lowest index wins; high numbers may wait under a storm
    for (int i = NUM_ALM - 1; i >= 0; i--) begin
      if (pend_set[i] || pend_ack[i] || pend_clr[i]) begin
        found = 1'b1;
        found_id = ALM_ID_W'(i);
        if (pend_clr[i]) begin
          found_kind = LOG_CLR;
        end else if (pend_set[i]) begin
          found_kind = LOG_SET;
        end else begin
          found_kind = LOG_ACK;
        end
      end
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = s;
    n.ms_cnt = ms_tick ? '0 : s.ms_cnt + 1'b1;
    // half period counted in milliseconds
    // free-running, so every alarm flashes in the same phase
    if (ms_tick) begin
      if (s.flash_cnt == FLASH_HALF_MS - 10'h001) begin
        n.flash_cnt = '0;
        n.flash_ph = ~s.flash_ph;
      end else begin
        n.flash_cnt = s.flash_cnt + 10'h001;
      end
    end
    // no latching: an alarm clears as soon as its cause goes
    n.active = cond;
    // new alarm beats a same-cycle acknowledge
    n.unacked = cond & ((cond & ~s.active) | (s.unacked & ~{NUM_ALM{ack_i}}));
    any_act = |n.active;
    any_unack = |n.unacked;
    n.common = any_act;
    n.alarm_led = any_unack ? n.flash_ph : any_act;
    for (int d = 0; d < NUM_DOUT; d++) begin
      if (alarm_out_sel_i == DOUT_SEL_W'(d)) begin
        // closed means 1; open on alarm, inverted when nc
        n.dout[d] = ~any_act ^ alarm_out_nc_i;
      end else begin
        n.dout[d] = dout_user_i[d];
      end
    end
    n.run_led = ~fault_i;
    n.in_op = ~fault_i;
    n.in_fault = fault_i;
    // one record at a time, held until taken
    case (s.lstate)
      LOG_IDLE: begin
        if (found) begin
          n.log_id = found_id;
          n.log_kind = found_kind;
          n.lstate = LOG_BUSY;
        end
      end
      LOG_BUSY: begin
        if (log_ready_i) begin
          n.lstate = LOG_IDLE;
          case (s.log_kind)
            LOG_SET: begin
              n.logged_act[s.log_id] = 1'b1;
              n.logged_ack[s.log_id] = 1'b0;
            end
            LOG_ACK: begin
              n.logged_ack[s.log_id] = 1'b1;
            end
            default: begin
              n.logged_act[s.log_id] = 1'b0;
              n.logged_ack[s.log_id] = 1'b0;
            end
          endcase
        end
      end
      default: begin
        n.lstate = LOG_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // all registered, so contacts never see a decode glitch
  assign common_alarm_o = s.common;
  assign alarm_led_o = s.alarm_led;
  assign dout_o = s.dout;
  assign run_led_o = s.run_led;
  assign in_op_contact_o = s.in_op;
  assign in_fault_contact_o = s.in_fault;
  assign log_valid_o = (s.lstate == LOG_BUSY);
  assign log_id_o = s.log_id;
  assign log_kind_o = s.log_kind;
  assign alarm_active_o = s.active;
  assign alarm_unacked_o = s.unacked;
endmodule

// ### tb/cao_alarm_top_sva.sv
/*
  Port-level assertions for the common alarm block.
  Assumes binding into cao_alarm_top, one clock, sync reset.
*/
`timescale 1ns/1ns
module cao_alarm_sva #(
  parameter int CYC_PER_MS = 4
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic ack_i,
  input wire logic fault_i,
  input wire logic [cao_pkg::DOUT_SEL_W-1:0] alarm_out_sel_i,
  input wire logic alarm_out_nc_i,
  input wire logic log_ready_i,
  input wire logic common_alarm_o,
  input wire logic alarm_led_o,
  input wire logic [cao_pkg::NUM_DOUT-1:0] dout_o,
  input wire logic run_led_o,
  input wire logic in_op_contact_o,
  input wire logic in_fault_contact_o,
  input wire logic log_valid_o,
  input wire logic [cao_pkg::ALM_ID_W-1:0] log_id_o,
  input wire logic [1:0] log_kind_o,
  input wire logic [cao_pkg::NUM_ALM-1:0] alarm_active_o,
  input wire logic [cao_pkg::NUM_ALM-1:0] alarm_unacked_o
);
  import cao_pkg::*;
  localparam int HALF = 500 * CYC_PER_MS;
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] age;
    logic led;
    logic [31:0] flash;
  } cao_chk_t;
  cao_chk_t st;
  cao_chk_t next_st;
  always_comb begin
    next_st = st;
    next_st.led = alarm_led_o;
    next_st.flash = '0;
    if (st.age != 2'h3) begin
      next_st.age = st.age + 2'h1;
    end
    // cycles the lamp stood still while something is unacked
    if (|alarm_unacked_o && alarm_led_o == st.led) begin
      next_st.flash = st.flash + 32'h1;
    end
    if (srst_i) begin
      next_st = '0;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    st <= next_st;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_common_any: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    common_alarm_o == (|alarm_active_o)) else $error("common alarm not or of alarms");
  a_alarm_contact: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    st.age == 2'h3 && $stable(alarm_out_sel_i) && $stable(alarm_out_nc_i)
    |-> dout_o[alarm_out_sel_i] == (common_alarm_o ~^ alarm_out_nc_i))
    else $error("alarm contact sense wrong");
  a_lamp_dark: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !common_alarm_o |-> !alarm_led_o) else $error("lamp lit without alarm");
  a_lamp_steady: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    common_alarm_o && alarm_unacked_o == '0 |-> alarm_led_o) else $error("lamp not steady");
  a_flash_period: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    st.flash < HALF) else $error("lamp flash too slow");
  a_unacked_subset: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (alarm_unacked_o & ~alarm_active_o) == '0) else $error("unacked alarm not active");
  a_status_pair: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    st.age == 2'h3 |-> run_led_o == !$past(fault_i) && in_op_contact_o == !$past(fault_i)
    && in_fault_contact_o == $past(fault_i)) else $error("status outputs wrong");
  a_ack_clears: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ack_i |=> (alarm_unacked_o & $past(alarm_active_o)) == '0) else $error("ack ignored");
  a_log_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    log_valid_o && !log_ready_i |=> log_valid_o && $stable(log_id_o) && $stable(log_kind_o))
    else $error("log record dropped while stalled");
  a_log_gap: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    log_valid_o && log_ready_i |=> !log_valid_o) else $error("log record not retired");
  a_log_kind: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    log_valid_o |-> log_kind_o != 2'h0 && log_id_o < NUM_ALM) else $error("bad log record");
endmodule
bind cao_alarm_top cao_alarm_sva #(.CYC_PER_MS(CYC_PER_MS)) u_cao_alarm_sva (
  .ref_clk_i, .srst_i, .ack_i, .fault_i, .alarm_out_sel_i, .alarm_out_nc_i, .log_ready_i,
  .common_alarm_o, .alarm_led_o, .dout_o, .run_led_o, .in_op_contact_o, .in_fault_contact_o,
  .log_valid_o, .log_id_o, .log_kind_o, .alarm_active_o, .alarm_unacked_o
);

// ### tb/cao_log_sink.sv
/*
  Far-side model: the alarm log recorder taking records.
  Assumes same clock as the block; ready is registered.
*/
`timescale 1ns/1ns
module cao_log_sink (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic slow_i,
  input wire logic log_valid_i,
  input wire logic [5:0] log_id_i,
  input wire logic [1:0] log_kind_i,
  output logic log_ready_o,
  output logic [5:0] last_id_o,
  output logic [1:0] last_kind_o
);
  typedef struct packed {
    logic [1:0] div;
    logic rdy;
    logic [5:0] id;
    logic [1:0] kind;
  } cao_sink_t;
  cao_sink_t st;
  cao_sink_t next_st;
  always_comb begin
    next_st = st;
    next_st.div = st.div + 2'h1;
    // slow mode stalls three cycles of four
    next_st.rdy = !slow_i || st.div == 2'h3;
    if (log_valid_i && st.rdy) begin
      next_st.id = log_id_i;
      next_st.kind = log_kind_i;
    end
    if (srst_i) begin
      next_st = '0;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    st <= next_st;
  end
  assign log_ready_o = st.rdy;
  assign last_id_o = st.id;
  assign last_kind_o = st.kind;
endmodule

// ### tb/cao_alarm_top_tb_top.sv
/*
  Self-checking bench for the common alarm block.
  Assumes the package, design, checker and log sink compiled first.
*/
`timescale 1ns/1ns
module cao_alarm_top_tb_top;
  import cao_pkg::*;
  localparam int CPM = 4;
  localparam int HALF = 500 * CPM;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [NUM_CH-1:0][VAL_W-1:0] val, up, upup, lo, lower_lower_limit, shi, slo;
  logic [NUM_CH-1:0][EN_W-1:0] en;
  logic [NUM_CH-1:0] fresh, rfail;
  logic [NUM_CH-1:0][15:0] tmo, freq;
  logic [NUM_CH-1:0][31:0] blog;
  logic [15:0] pmax;
  logic [NUM_STR-1:0][VAL_W-1:0] flow, qmax, cut, dp, dpcut;
  logic [NUM_STR-1:0][7:0] load, iter;
  logic [NUM_STR-1:0][NUM_COMP-1:0][15:0] comp;
  logic [NUM_STR-1:0] conv;
  logic ack, fault, nc, rdy, slow, common, led, run, in_op, in_flt, lvalid;
  logic [DOUT_SEL_W-1:0] sel;
  logic [NUM_DOUT-1:0] user, dout;
  logic [ALM_ID_W-1:0] lid, sid;
  logic [1:0] lkind, skind;
  logic [NUM_ALM-1:0] act, unack;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  cao_alarm_top #(.CYC_PER_MS(CPM)) u_cao_alarm_top (
    .ref_clk_i(clk), .srst_i(rst), .ch_value_i(val), .ch_upper_limit_i(up),
    .ch_upper_upper_limit_i(upup), .ch_lower_limit_i(lo), .ch_lower_lower_limit_i(lower_lower_limit),
    .ch_scale_hi_i(shi), .ch_scale_lo_i(slo), .ch_limit_en_i(en), .ch_fresh_i(fresh),
    .ch_timeout_ms_i(tmo), .ch_read_fail_i(rfail), .ch_freq_hz_i(freq),
    .ch_pulse_backlog_i(blog), .pulse_out_max_hz_i(pmax), .st_uncorrected_volume_flow_i(flow),
    .st_max_flow_i(qmax), .st_max_load_factor_i(load), .st_cutoff_flow_i(cut),
    .st_differential_pressure_i(dp), .st_dp_cutoff_i(dpcut), .st_comp_i(comp),
    .st_iter_i(iter), .st_converged_i(conv), .ack_i(ack), .fault_i(fault),
    .alarm_out_sel_i(sel), .alarm_out_nc_i(nc), .dout_user_i(user), .log_ready_i(rdy),
    .common_alarm_o(common), .alarm_led_o(led), .dout_o(dout), .run_led_o(run),
    .in_op_contact_o(in_op), .in_fault_contact_o(in_flt), .log_valid_o(lvalid),
    .log_id_o(lid), .log_kind_o(lkind), .alarm_active_o(act), .alarm_unacked_o(unack)
  );
  cao_log_sink u_cao_log_sink (
    .ref_clk_i(clk), .srst_i(rst), .slow_i(slow), .log_valid_i(lvalid), .log_id_i(lid),
    .log_kind_i(lkind), .log_ready_o(rdy), .last_id_o(sid), .last_kind_o(skind)
  );
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(negedge clk);
  endtask
  function automatic logic [NUM_ALM-1:0] oh(int i);
    logic [NUM_ALM-1:0] e;
    e = '0;
    e[i] = 1'b1;
    return e;
  endfunction
  // quiet inputs: every limit out of reach, composition at 100 %
  task automatic idle();
    {val, lo, lower_lower_limit, slo, en, fresh, tmo, rfail, freq, blog} = '0;
    {up, upup, shi} = '1;
    {flow, cut, dp, dpcut, iter, ack, fault, sel, nc, user, slow} = '0;
    pmax = 16'h0064;
    qmax = {2{16'h03e8}};
    load = {2{8'h64}};
    comp = {8{16'h09c4}};
    conv = '1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_hi_ack();
    logic b;
    slow = 1'b1;
    en[1] = 6'h01;
    up[1] = 16'h0100;
    val[1] = 16'h0101;
    wt(3);
    chk("active", oh(11), act);
    chk("common", 1'b1, common);
    chk("contact", 1'b0, dout[0]);
    wt(10);
    chk("log set", {6'h0b, 2'h1}, {sid, skind});
    b = ~led;
    wt(HALF);
    chk("flash", b, led);
    ack = 1'b1;
    wt(1);
    ack = 1'b0;
    wt(2);
    chk("unacked", '0, unack);
    chk("steady", 1'b1, led);
    wt(10);
    chk("log ack", {6'h0b, 2'h2}, {sid, skind});
    val[1] = 16'h0100;
    wt(3);
    chk("cleared", {1'b0, 1'b0, 1'b1}, {common, led, dout[0]});
    wt(10);
    chk("log clr", {6'h0b, 2'h3}, {sid, skind});
  endtask
  task automatic t_limits();
    int pos[6] = '{A_HI, A_UPPER_UPPER_LIMIT, A_LO, A_LOWER_LOWER_LIMIT, A_OVER, A_UNDER};
    val[2] = 16'h0064;
    {up[2], upup[2], shi[2]} = {3{16'h0063}};
    {lo[2], lower_lower_limit[2], slo[2]} = {3{16'h0065}};
    wt(3);
    chk("disabled", '0, act);
    for (int j = 0; j < 6; j++) begin
      en[2] = 6'h01 << j;
      wt(3);
      chk("limit", oh(20 + pos[j]), act);
    end
  endtask
  task automatic t_pulse();
    freq[3] = 16'h2ee0;
    blog[3] = 32'h000003e8;
    wt(3);
    chk("at limits", '0, act);
    freq[3] = 16'h2ee1;
    wt(3);
    chk("freq", oh(37), act);
    freq[3] = '0;
    blog[3] = 32'h000003e9;
    wt(3);
    chk("backlog", oh(38), act);
    blog[3] = '0;
    rfail[3] = 1'b1;
    wt(3);
    chk("read fail", oh(33), act);
  endtask
  task automatic t_timeout();
    tmo[0] = 16'h0003;
    fresh[0] = 1'b1;
    wt(1);
    fresh[0] = 1'b0;
    wt(5);
    chk("young", '0, act);
    wt(10);
    chk("stale", oh(0), act);
    fresh[0] = 1'b1;
    wt(1);
    fresh[0] = 1'b0;
    wt(4);
    chk("refreshed", '0, act);
  endtask
  task automatic t_stream();
    flow[0] = 16'h05dc;
    wt(3);
    chk("crit edge", '0, act);
    flow[0] = 16'h05dd;
    wt(3);
    chk("crit", oh(40), act);
    flow[0] = 16'h0031;
    cut[0] = 16'h0032;
    wt(3);
    chk("cutoff", oh(41), act);
    flow[0] = '0;
    dp[0] = 16'h0005;
    dpcut[0] = 16'h0006;
    wt(3);
    chk("dp", oh(42), act);
    dp[0] = 16'h0006;
    comp[0][3] = 16'h07cf;
    wt(3);
    chk("comp", oh(43), act);
    comp[0][3] = 16'h0bb8;
    wt(3);
    chk("comp top edge", '0, act);
    comp[0][3] = 16'h0bb9;
    wt(3);
    chk("comp high", oh(43), act);
    comp[0][3] = 16'h07d0;
    iter[0] = 8'h09;
    conv[0] = 1'b0;
    wt(3);
    chk("iter nine", '0, act);
    iter[0] = 8'h0a;
    wt(3);
    chk("calc", oh(44), act);
  endtask
  task automatic t_contacts();
    logic [7:0] e;
    for (int s = 0; s < 8; s++) begin
      sel = s[2:0];
      nc = s[0];
      user = 8'h5a ^ s[7:0];
      rfail[0] = s[1];
      wt(3);
      e = user;
      e[s] = ~(s[1] ^ s[0]);
      chk("dout", e, dout);
    end
    fault = 1'b1;
    wt(2);
    chk("faulty", 3'h1, {run, in_op, in_flt});
    fault = 1'b0;
    wt(2);
    chk("operating", 3'h6, {run, in_op, in_flt});
  endtask
  initial begin
    idle();
    wt(16);
    rst = 1'b0;
    wt(2);
    t_hi_ack();
    idle();
    wt(4);
    t_limits();
    idle();
    wt(4);
    t_pulse();
    idle();
    wt(4);
    t_timeout();
    idle();
    wt(4);
    t_stream();
    idle();
    wt(4);
    t_contacts();
    stop_test();
  end
endmodule
